//--- ird_defs.svh
// Register offsets, field positions, reset values and setting limits of the inrush detector
`ifndef IRD_DEFS_SVH
`define IRD_DEFS_SVH

`define IRD_ADDR_W        5
`define IRD_OFS_CTRL      5'h00
`define IRD_OFS_RATIO     5'h04
`define IRD_OFS_SENS      5'h08
`define IRD_OFS_FLAGS     5'h0C
`define IRD_OFS_IRQ_STAT  5'h10
`define IRD_OFS_IRQ_EN    5'h14
`define IRD_OFS_IRQ_CLR   5'h18

`define IRD_CTRL_OP_BIT   0
`define IRD_FLAG_GEN_BIT  3

`define IRD_RATIO_W       6
`define IRD_RATIO_MIN     6'h05
`define IRD_RATIO_MAX     6'h32
`define IRD_RATIO_RST     6'h0F
`define IRD_SENS_W        7
`define IRD_SENS_MIN      7'h14
`define IRD_SENS_MAX      7'h64
`define IRD_SENS_RST      7'h1E
`define IRD_PERCENT       8'h64

`define IRD_RESP_OKAY     2'h0
`define IRD_RESP_SLVERR   2'h2

`endif

//--- ird_pkg.sv
// Types shared by the inrush detector
package ird_pkg;
  typedef enum logic {IRD_OP_OFF, IRD_OP_ON} ird_op_type;
  typedef logic [3:0] ird_flags_type;
endpackage

//--- ird_inrush_detector.sv
// Three-phase second-harmonic inrush detector with AXI4-Lite settings and interrupts
//
// Operation
// - Flag phase when harmonic ratio exceeds setting
// - Suppress flag unless fundamental above sensitivity
// - Each phase decided and flagged independently
// - General flag is OR of phases
// - Disable input holds all flags low
// - Operation off produces no flags
`include "ird_defs.svh"

module ird_inrush_detector
#(
  parameter int MAG_W     = 16,
  parameter int RATED_MAG = 1000
)
(
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write address
  input  wire logic [`IRD_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output      logic                   s_axi_awready,
  // AXI4-Lite write data and response
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output      logic                   s_axi_wready,
  output      logic [1:0]             s_axi_bresp,
  output      logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`IRD_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output      logic                   s_axi_arready,
  output      logic [31:0]            s_axi_rdata,
  output      logic [1:0]             s_axi_rresp,
  output      logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Magnitudes from the Fourier stage, phases a, b, c in MAG_W-bit slices 0, 1, 2
  input  wire logic                   sample_valid,
  input  wire logic [3*MAG_W-1:0]     fund_mag,
  input  wire logic [3*MAG_W-1:0]     harm2_mag,
  // User disable
  input  wire logic                   disable_in,
  // Detection outputs
  output      logic [2:0]             phase_inrush,
  output      logic                   general_inrush,
  output      logic                   irq
);
  import ird_pkg::*;

  localparam int PROD_W = MAG_W + 16;

  // Settings and status
  ird_op_type              op_r, op_nxt;
  logic [`IRD_RATIO_W-1:0] ratio_r, ratio_nxt;
  logic [`IRD_SENS_W-1:0]  sens_r, sens_nxt;
  ird_flags_type           flags_r, flags_nxt;
  ird_flags_type           stat_r, stat_nxt;
  ird_flags_type           en_r, en_nxt;
  logic [2:0]              hit;
  logic                    gate_off;

  // Bus state
  logic                    aw_got_r, aw_got_nxt;
  logic                    w_got_r, w_got_nxt;
  logic [`IRD_ADDR_W-1:0]  waddr_r, waddr_nxt;
  logic [31:0]             wdata_r, wdata_nxt;
  logic                    wstrb0_r, wstrb0_nxt;
  logic                    bvalid_r, bvalid_nxt;
  logic [1:0]              bresp_r, bresp_nxt;
  logic                    rvalid_r, rvalid_nxt;
  logic [1:0]              rresp_r, rresp_nxt;
  logic [31:0]             rdata_r, rdata_nxt;
  logic                    do_write;
  ird_flags_type           clr_mask;

  // Per-phase decision: ratio test and sensitivity gate, both division free
  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    logic [PROD_W-1:0] h2_pct, ratio_fund, fund_pct, sens_rated;
    assign h2_pct     = PROD_W'(harm2_mag[p*MAG_W +: MAG_W]) * PROD_W'(`IRD_PERCENT);
    assign ratio_fund = PROD_W'(fund_mag[p*MAG_W +: MAG_W]) * PROD_W'(ratio_r);
    assign fund_pct   = PROD_W'(fund_mag[p*MAG_W +: MAG_W]) * PROD_W'(`IRD_PERCENT);
    assign sens_rated = PROD_W'(sens_r) * PROD_W'(RATED_MAG);
    // Both tests are strict: equality neither detects nor passes the gate
    assign hit[p] = (h2_pct > ratio_fund) && (fund_pct > sens_rated);
  end

  assign gate_off = (op_r == IRD_OP_OFF) || disable_in;

  // Detection flags
  always_comb
  begin
    flags_nxt = flags_r;
    if (gate_off)
    begin
      flags_nxt = '0;
    end
    else if (sample_valid)
    begin
      flags_nxt[2:0] = hit;
    end
    flags_nxt[`IRD_FLAG_GEN_BIT] = |flags_nxt[2:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_r <= '0;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  assign phase_inrush   = flags_r[2:0];
  assign general_inrush = flags_r[`IRD_FLAG_GEN_BIT];

  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign do_write      = aw_got_r && w_got_r && !bvalid_r;

  always_comb
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    waddr_nxt  = waddr_r;
    wdata_nxt  = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_nxt = 1'b1;
      waddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_nxt  = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      unique case (waddr_r)
        `IRD_OFS_CTRL, `IRD_OFS_RATIO, `IRD_OFS_SENS,
        `IRD_OFS_IRQ_EN, `IRD_OFS_IRQ_CLR: bresp_nxt = `IRD_RESP_OKAY;
        default:                           bresp_nxt = `IRD_RESP_SLVERR;
      endcase
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
  end

  // Settings and interrupt registers; settings whose low data byte is out of range are clamped
  always_comb
  begin
    op_nxt    = op_r;
    ratio_nxt = ratio_r;
    sens_nxt  = sens_r;
    en_nxt    = en_r;
    clr_mask  = '0;
    if (do_write && wstrb0_r)
    begin
      unique case (waddr_r)
        `IRD_OFS_CTRL:
          op_nxt = wdata_r[`IRD_CTRL_OP_BIT] ? IRD_OP_ON : IRD_OP_OFF;
        `IRD_OFS_RATIO:
          if (wdata_r[7:0] < 8'(`IRD_RATIO_MIN))
            ratio_nxt = `IRD_RATIO_MIN;
          else if (wdata_r[7:0] > 8'(`IRD_RATIO_MAX))
            ratio_nxt = `IRD_RATIO_MAX;
          else
            ratio_nxt = wdata_r[`IRD_RATIO_W-1:0];
        `IRD_OFS_SENS:
          if (wdata_r[7:0] < 8'(`IRD_SENS_MIN))
            sens_nxt = `IRD_SENS_MIN;
          else if (wdata_r[7:0] > 8'(`IRD_SENS_MAX))
            sens_nxt = `IRD_SENS_MAX;
          else
            sens_nxt = wdata_r[`IRD_SENS_W-1:0];
        `IRD_OFS_IRQ_EN:  en_nxt   = wdata_r[3:0];
        `IRD_OFS_IRQ_CLR: clr_mask = wdata_r[3:0];
        default:          ;
      endcase
    end
    // A rising flag in the clearing cycle survives the clear
    stat_nxt = (stat_r & ~clr_mask) | (flags_nxt & ~flags_r);
  end

  assign irq = |(stat_r & en_r);

  // Read channel: answer one cycle after the address is taken
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `IRD_RESP_OKAY;
      unique case (s_axi_araddr)
        `IRD_OFS_CTRL:     rdata_nxt = {31'h0, op_r == IRD_OP_ON};
        `IRD_OFS_RATIO:    rdata_nxt = {26'h0, ratio_r};
        `IRD_OFS_SENS:     rdata_nxt = {25'h0, sens_r};
        `IRD_OFS_FLAGS:    rdata_nxt = {28'h0, flags_r};
        `IRD_OFS_IRQ_STAT: rdata_nxt = {28'h0, stat_r};
        `IRD_OFS_IRQ_EN:   rdata_nxt = {28'h0, en_r};
        `IRD_OFS_IRQ_CLR:  rdata_nxt = 32'h0;
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = `IRD_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_r     <= IRD_OP_ON;
      ratio_r  <= `IRD_RATIO_RST;
      sens_r   <= `IRD_SENS_RST;
      en_r     <= '0;
      stat_r   <= '0;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      waddr_r  <= '0;
      wdata_r  <= 32'h0;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= `IRD_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= `IRD_RESP_OKAY;
    end
    else
    begin
      op_r     <= op_nxt;
      ratio_r  <= ratio_nxt;
      sens_r   <= sens_nxt;
      en_r     <= en_nxt;
      stat_r   <= stat_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      waddr_r  <= waddr_nxt;
      wdata_r  <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_live_sample;
    sample_valid && !gate_off;
  endsequence

  sequence s_write_pair;
    do_write;
  endsequence

  a_flag_follows_hit: assert property (s_live_sample |=> phase_inrush == $past(hit))
    else $error("phase flags did not take the sample decision");
  a_phase_b_alone: assert property (s_live_sample ##0 hit[1] |=> phase_inrush[1])
    else $error("phase b flag missed its own decision");
  a_ratio_compare: assert property (s_live_sample ##0
      (PROD_W'(harm2_mag[MAG_W-1:0]) * PROD_W'(`IRD_PERCENT)
       <= PROD_W'(fund_mag[MAG_W-1:0]) * PROD_W'(ratio_r)) |=> !phase_inrush[0])
    else $error("phase a flagged without ratio exceeded");
  a_sens_gate: assert property (s_live_sample ##0
      (PROD_W'(fund_mag[2*MAG_W +: MAG_W]) * PROD_W'(`IRD_PERCENT)
       <= PROD_W'(sens_r) * PROD_W'(RATED_MAG)) |=> !phase_inrush[2])
    else $error("phase c flagged below sensitivity");
  a_ratio_range: assert property (ratio_r >= `IRD_RATIO_MIN && ratio_r <= `IRD_RATIO_MAX)
    else $error("ratio setting out of range");
  a_general_or: assert property (general_inrush == |phase_inrush)
    else $error("general flag differs from phase OR");
  a_disable_clear: assert property (disable_in |=> (phase_inrush == 3'h0) && !general_inrush)
    else $error("flags set while disabled");
  a_op_off_clear: assert property (op_r == IRD_OP_OFF |=> phase_inrush == 3'h0)
    else $error("flags set while operation off");
  a_hold_between: assert property (!sample_valid && !gate_off |=> $stable(phase_inrush))
    else $error("flags changed without a sample");
  a_write_answer: assert property (s_write_pair |=> s_axi_bvalid)
    else $error("write not answered");
  a_event_sticky: assert property (!flags_r[0] ##1 flags_r[0] |-> stat_r[0])
    else $error("rising phase a flag did not set status");

endmodule // ird_inrush_detector

//--- ird_fourier_model.sv
// Behavioural Fourier stage that hands magnitude samples to the detector
module ird_fourier_model
#(
  parameter int MAG_W = 16
)
(
  // Clock
  input  wire logic               aclk,
  // Sample request from the bench, held one cycle
  input  wire logic               req,
  input  wire logic [3*MAG_W-1:0] fund_in,
  input  wire logic [3*MAG_W-1:0] harm2_in,
  // Magnitudes to the detector
  output      logic               sample_valid,
  output      logic [3*MAG_W-1:0] fund_mag,
  output      logic [3*MAG_W-1:0] harm2_mag
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    sample_valid = 1'b0;
    fund_mag     = '0;
    harm2_mag    = '0;
  end

  // A late request simply delays the sample; all three phases always travel together
  always @(posedge aclk)
  begin
    sample_valid <= req;
    // Between samples the lines toggle, so a stale value is never mistaken for data
    fund_mag     <= req ? fund_in : ~fund_mag;
    harm2_mag    <= req ? harm2_in : ~harm2_mag;
  end
endmodule // ird_fourier_model

//--- ird_inrush_detector_tb.sv
// Bench for the inrush detector: register bus, detection and interrupts
`include "ird_defs.svh"

module ird_inrush_detector_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, awvalid, wvalid, bready, bvalid, arvalid, rready, rvalid;
  logic        awready, wready, arready, req, sv, disable_in, general_inrush, irq;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  phase_inrush;
  logic [47:0] fund_in, harm2_in, fund_mag, harm2_mag;
  int          fails, total_checks, cycles;

  ird_inrush_detector ird_inrush_detector_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(sv), .fund_mag(fund_mag), .harm2_mag(harm2_mag),
    .disable_in(disable_in), .phase_inrush(phase_inrush),
    .general_inrush(general_inrush), .irq(irq));
  ird_fourier_model ird_fourier_model_inst (
    .aclk(aclk), .req(req), .fund_in(fund_in), .harm2_in(harm2_in),
    .sample_valid(sv), .fund_mag(fund_mag), .harm2_mag(harm2_mag));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge aclk);
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask

  task automatic axi_read(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge aclk);
    rready <= 1'b0;
    check("rresp", rresp, er);
    check("rdata", rdata, e);
  endtask

  // Request goes to the model, which presents it one edge later for the detector to take
  task automatic sample(input logic [47:0] f, input logic [47:0] h, input logic [3:0] e);
    @(posedge aclk);
    fund_in <= f;
    harm2_in <= h;
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    @(posedge aclk);
    @(posedge aclk);
    check("flags", {28'h0, general_inrush, phase_inrush}, {28'h0, e});
  endtask

  task automatic t_reset();
    logic [4:0]  a[6] = '{`IRD_OFS_CTRL, `IRD_OFS_RATIO, `IRD_OFS_SENS, `IRD_OFS_FLAGS,
                          `IRD_OFS_IRQ_STAT, `IRD_OFS_IRQ_EN};
    logic [31:0] v[6] = '{32'h1, 32'h0F, 32'h1E, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++)
      axi_read(a[i], v[i], `IRD_RESP_OKAY);
    axi_read(5'h1C, 32'h0, `IRD_RESP_SLVERR);
    // Phase a at the ratio limit, b just over, c with fundamental at the sensitivity limit
    sample({16'h012C, 16'h03E8, 16'h03E8}, {16'h03E7, 16'h0097, 16'h0096}, 4'hA);
  endtask

  task automatic t_limits();
    int r[3] = '{5, 15, 50};
    int s[3] = '{20, 100, 30};
    // At full sensitivity phase b sits exactly on the gate and stays quiet
    logic [3:0] e[3][2] = '{'{4'hA, 4'hE}, '{4'h0, 4'hC}, '{4'hA, 4'hE}};
    for (int i = 0; i < 3; i++)
    begin
      axi_write(`IRD_OFS_RATIO, 32'(r[i]), `IRD_RESP_OKAY);
      axi_write(`IRD_OFS_SENS, 32'(s[i]), `IRD_RESP_OKAY);
      for (int k = 0; k < 2; k++)
        sample({16'(s[i] * 10 + k), 16'h03E8, 16'h03E8},
               {16'h1388, 16'(r[i] * 10 + 1), 16'(r[i] * 10)}, e[i][k]);
    end
    // Settings written outside their spans land on the nearest limit
    axi_write(`IRD_OFS_RATIO, 32'h3, `IRD_RESP_OKAY);
    axi_read(`IRD_OFS_RATIO, 32'h05, `IRD_RESP_OKAY);
    axi_write(`IRD_OFS_RATIO, 32'h40, `IRD_RESP_OKAY);
    axi_read(`IRD_OFS_RATIO, 32'h32, `IRD_RESP_OKAY);
    axi_write(`IRD_OFS_SENS, 32'h10, `IRD_RESP_OKAY);
    axi_read(`IRD_OFS_SENS, 32'h14, `IRD_RESP_OKAY);
    axi_write(`IRD_OFS_SENS, 32'h7F, `IRD_RESP_OKAY);
    axi_read(`IRD_OFS_SENS, 32'h64, `IRD_RESP_OKAY);
    // With byte lane 0 off the write is answered but leaves the setting alone
    wstrb <= 4'hE;
    axi_write(`IRD_OFS_RATIO, 32'h14, `IRD_RESP_OKAY);
    wstrb <= 4'hF;
    axi_read(`IRD_OFS_RATIO, 32'h32, `IRD_RESP_OKAY);
  endtask

  task automatic t_gate();
    logic [47:0] f = {3{16'h07D0}};
    sample(f, f, 4'hF);
    disable_in <= 1'b1;
    sample(f, f, 4'h0);
    disable_in <= 1'b0;
    sample(f, f, 4'hF);
    axi_write(`IRD_OFS_CTRL, 32'h0, `IRD_RESP_OKAY);
    sample(f, f, 4'h0);
    axi_write(`IRD_OFS_CTRL, 32'h1, `IRD_RESP_OKAY);
  endtask

  task automatic t_irq();
    logic [47:0] f = {3{16'h07D0}};
    axi_write(`IRD_OFS_IRQ_CLR, 32'hF, `IRD_RESP_OKAY);
    axi_read(`IRD_OFS_IRQ_STAT, 32'h0, `IRD_RESP_OKAY);
    sample(f, f, 4'hF);
    axi_read(`IRD_OFS_IRQ_STAT, 32'hF, `IRD_RESP_OKAY);
    check("irq", {31'h0, irq}, 32'h0);
    axi_write(`IRD_OFS_IRQ_EN, 32'h8, `IRD_RESP_OKAY);
    check("irq", {31'h0, irq}, 32'h1);
    axi_write(`IRD_OFS_IRQ_CLR, 32'h8, `IRD_RESP_OKAY);
    check("irq", {31'h0, irq}, 32'h0);
    axi_read(`IRD_OFS_IRQ_STAT, 32'h7, `IRD_RESP_OKAY);
    axi_read(`IRD_OFS_IRQ_CLR, 32'h0, `IRD_RESP_OKAY);
    axi_write(`IRD_OFS_FLAGS, 32'h0, `IRD_RESP_SLVERR);
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Whole run needs under two hundred cycles; a hang stops well past that
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, req, disable_in} = 8'h00;
    {awaddr, araddr, wdata, fund_in, harm2_in} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_limits();
    t_gate();
    t_irq();
    finish_test();
  end
endmodule // ird_inrush_detector_tb
